// ---- tb/vta_vlan_table_asserts.sv ----
// Concurrent checks on the ports of the VLAN table access block.
// Assumes one clock ref_clk and a synchronous active-high rst.
`timescale 1ns/10ps
module vta_vlan_table_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register bus
   input wire logic [vta_pkg::VTA_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Per-port controls
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] admit_nonmember_control,
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] egress_port_type_config,
   // Packet descriptor
   input wire logic pkt_valid,
   input wire logic [1:0] pkt_port,
   input wire logic pkt_tagged,
   input wire logic [11:0] pkt_vid,
   input wire logic [2:0] pkt_pri,
   // Lookup result
   input wire logic res_valid,
   input wire logic res_accept,
   input wire logic [11:0] res_vid,
   input wire logic [2:0] res_pri,
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] res_egress_member,
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] res_strip_tag
);
   import vta_pkg::*;

   // ==========================================================
   // Accepted bus transfers
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_cmd_taken;
      avs_write && !avs_waitrequest && avs_address == VTA_ADDR_CMD && avs_byteenable[0];
   endsequence
   sequence s_sts_taken;
      avs_read && !avs_waitrequest && avs_address == VTA_ADDR_STS;
   endsequence
   sequence s_rd_taken;
      avs_read && !avs_waitrequest && avs_address == VTA_ADDR_RD;
   endsequence

   // ==========================================================
   // Register side
   chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait state not exactly one cycle");
   chk_rd_reserved: assert property (s_rd_taken |-> avs_readdata[31:18] == 14'h0000)
      else $error("reserved result bits not zero");
   chk_rd_steady: assert property ($changed(avs_readdata)
      |-> !avs_waitrequest && $past(avs_read)) else $error("read data moved without a read");
   chk_pend_set: assert property (s_cmd_taken ##[2:3] s_sts_taken
      |-> avs_readdata[VTA_STS_PEND]) else $error("pending not set after command");
   chk_pend_clear: assert property (s_cmd_taken ##[4:6] s_sts_taken
      |-> !avs_readdata[VTA_STS_PEND]) else $error("pending not cleared after command");

   // ==========================================================
   // Packet side
   chk_res_pulse: assert property (res_valid == $past(pkt_valid))
      else $error("result strobe not one cycle after descriptor");
   chk_admit_accept: assert property (pkt_valid && pkt_port != 2'h3
      && admit_nonmember_control[pkt_port] |=> res_accept) else $error("admitted packet dropped");
   chk_strip_hybrid: assert property (res_valid
      |-> (res_strip_tag & ~$past(egress_port_type_config)) == 3'h0) else $error("strip on trunk");
   chk_strip_member: assert property (res_valid
      |-> (res_strip_tag & ~res_egress_member) == 3'h0) else $error("strip on non-member");
   chk_tag_vid: assert property (pkt_valid && pkt_tagged && pkt_vid != VTA_NULL_VID
      |=> res_vid == $past(pkt_vid) && res_pri == $past(pkt_pri)) else $error("tag VID lost");
endmodule // vta_vlan_table_asserts

bind vta_vlan_table vta_vlan_table_asserts chk_u (
   .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .admit_nonmember_control(admit_nonmember_control),
   .egress_port_type_config(egress_port_type_config), .pkt_valid(pkt_valid),
   .pkt_port(pkt_port), .pkt_tagged(pkt_tagged), .pkt_vid(pkt_vid), .pkt_pri(pkt_pri),
   .res_valid(res_valid), .res_accept(res_accept), .res_vid(res_vid), .res_pri(res_pri),
   .res_egress_member(res_egress_member), .res_strip_tag(res_strip_tag)
);

// ---- tb/vta_vlan_table_tb_top.sv ----
// Self-checking bench for the VLAN table access block.
// Assumes the design package and the bound port checker are compiled first.
`timescale 1ns/10ps
module vta_vlan_table_tb_top;
   import vta_pkg::*;

   // ==========================================================
   // Row types and stimulus tables
   typedef struct packed {logic sel; logic [3:0] idx; logic [31:0] wdat; logic [17:0] rb;} vta_trow_t;
   typedef struct packed {
      logic [1:0] port; logic tag; logic [11:0] vid; logic [2:0] pri; logic [2:0] adm;
      logic [2:0] hyb; logic acc; logic [11:0] evid; logic [2:0] epri; logic [2:0] egr;
      logic [2:0] strip;
   } vta_prow_t;
   vta_trow_t trows [6] = '{
      '{1'b0, 4'h0, 32'h0003_a064, 18'h3_a064}, '{1'b0, 4'hf, 32'h0000_cabc, 18'h0_cabc},
      '{1'b0, 4'h3, 32'hfffc_3200, 18'h0_3200}, '{1'b1, 4'h3, 32'h0003_ffff, 18'h0_0000},
      '{1'b1, 4'h1, 32'h0003_f123, 18'h0_7123}, '{1'b1, 4'h2, 32'h0000_5064, 18'h0_5064}};
   vta_prow_t prows [12] = '{
      '{2'h2, 1'b1, 12'h064, 3'h3, 3'h0, 3'h5, 1'b1, 12'h064, 3'h3, 3'h7, 3'h5},
      '{2'h1, 1'b1, 12'h064, 3'h3, 3'h0, 3'h5, 1'b1, 12'h064, 3'h3, 3'h7, 3'h0},
      '{2'h2, 1'b1, 12'habc, 3'h1, 3'h0, 3'h0, 1'b0, 12'habc, 3'h1, 3'h2, 3'h0},
      '{2'h2, 1'b1, 12'habc, 3'h1, 3'h4, 3'h0, 1'b1, 12'habc, 3'h1, 3'h2, 3'h0},
      '{2'h1, 1'b1, 12'habc, 3'h2, 3'h0, 3'h2, 1'b1, 12'habc, 3'h2, 3'h2, 3'h2},
      '{2'h1, 1'b1, 12'habc, 3'h2, 3'h0, 3'h0, 1'b1, 12'habc, 3'h2, 3'h2, 3'h0},
      '{2'h2, 1'b0, 12'h777, 3'h0, 3'h0, 3'h7, 1'b1, 12'h064, 3'h5, 3'h7, 3'h7},
      '{2'h2, 1'b1, 12'h000, 3'h6, 3'h0, 3'h7, 1'b1, 12'h064, 3'h5, 3'h7, 3'h7},
      '{2'h0, 1'b0, 12'h123, 3'h4, 3'h0, 3'h7, 1'b0, 12'h000, 3'h0, 3'h0, 3'h0},
      '{2'h0, 1'b1, 12'h123, 3'h4, 3'h1, 3'h7, 1'b1, 12'h123, 3'h4, 3'h0, 3'h0},
      '{2'h0, 1'b1, 12'h200, 3'h1, 3'h0, 3'h1, 1'b1, 12'h200, 3'h1, 3'h1, 3'h1},
      '{2'h1, 1'b0, 12'h000, 3'h0, 3'h0, 3'h0, 1'b0, 12'h123, 3'h7, 3'h0, 3'h0}};

   // ==========================================================
   // Design signals and counters
   logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [15:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [2:0] admit, hyb, res_egress_member, res_strip_tag, pkt_pri, res_pri;
   logic pkt_valid, pkt_tagged, res_valid, res_accept;
   logic [1:0] pkt_port;
   logic [11:0] pkt_vid, res_vid;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   vta_vlan_table dut_u (
      .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .admit_nonmember_control(admit), .egress_port_type_config(hyb),
      .pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_tagged(pkt_tagged), .pkt_vid(pkt_vid),
      .pkt_pri(pkt_pri), .res_valid(res_valid), .res_accept(res_accept), .res_vid(res_vid),
      .res_pri(res_pri), .res_egress_member(res_egress_member), .res_strip_tag(res_strip_tag));

   // 40 MHz clock and hang guard
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   // ==========================================================
   // Compare, bus and packet tasks
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected register word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pkt(input logic [22:0] got, input logic [22:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected lookup result at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon transfer; held until waitrequest is seen low at a rising edge
   task automatic bus_xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Issue a table command, pending seen set then cleared
   task automatic do_cmd(input logic [5:0] c);
      bus_xfer(1'b1, VTA_ADDR_CMD, {26'h00_0000, c});
      bus_xfer(1'b0, VTA_ADDR_STS, 32'h0000_0000);
      chk_reg(q, 32'h0000_0001);
      bus_xfer(1'b0, VTA_ADDR_STS, 32'h0000_0000);
      chk_reg(q, 32'h0000_0000);
   endtask
   task automatic tbl_read(input logic sel, input logic [3:0] idx, input logic [17:0] exp);
      do_cmd({1'b1, sel, idx});
      bus_xfer(1'b0, VTA_ADDR_RD, 32'h0000_0000);
      chk_reg(q, {14'h0000, exp});
   endtask
   task automatic send_pkt(input vta_prow_t r);
      @(posedge ref_clk);
      {pkt_port, pkt_tagged, pkt_vid, pkt_pri} <= {r.port, r.tag, r.vid, r.pri};
      admit <= r.adm;
      hyb <= r.hyb;
      pkt_valid <= 1'b1;
      @(posedge ref_clk);
      pkt_valid <= 1'b0;
      @(negedge ref_clk);
      chk_pkt({res_valid, res_accept, res_vid, res_pri, res_egress_member, res_strip_tag},
         {1'b1, r.acc, r.evid, r.epri, r.egr, r.strip});
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      {pkt_valid, pkt_port, pkt_tagged, pkt_vid, pkt_pri, admit, hyb} = '0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset contents: result word, port defaults and one VLAN entry
      bus_xfer(1'b0, VTA_ADDR_RD, 32'h0000_0000);
      chk_reg(q, 32'h0000_0000);
      for (int i = 0; i < 4; i++) tbl_read(i < 3, 4'(i), 18'h0_0000);
      // Table rows: stage, write, read back
      foreach (trows[k]) begin
         bus_xfer(1'b1, VTA_ADDR_WR, trows[k].wdat);
         do_cmd({1'b0, trows[k].sel, trows[k].idx});
         tbl_read(trows[k].sel, trows[k].idx, trows[k].rb);
      end
      // Lookup rows against the programmed tables
      foreach (prows[k]) send_pkt(prows[k]);
      // Result word survives a write command and a write to itself
      bus_xfer(1'b1, VTA_ADDR_WR, 32'h0003_ffff);
      do_cmd(6'h08);
      bus_xfer(1'b1, VTA_ADDR_RD, 32'hffff_ffff);
      bus_xfer(1'b0, VTA_ADDR_RD, 32'h0000_0000);
      chk_reg(q, 32'h0000_5064);
      tbl_read(1'b0, 4'h8, 18'h3_ffff);
      // Unmapped word reads zero
      bus_xfer(1'b0, 16'h0000, 32'h0000_0000);
      chk_reg(q, 32'h0000_0000);
      // Command write without byte 0 is ignored, command word keeps last read
      avs_byteenable <= 4'he;
      bus_xfer(1'b1, VTA_ADDR_CMD, 32'h0000_0001);
      avs_byteenable <= 4'hf;
      bus_xfer(1'b0, VTA_ADDR_CMD, 32'h0000_0000);
      chk_reg(q, 32'h0000_0028);
      bus_xfer(1'b0, VTA_ADDR_STS, 32'h0000_0000);
      chk_reg(q, 32'h0000_0000);
      stop_test();
   end
endmodule // vta_vlan_table_tb_top

// ---- verilog/vta_lookup.sv ----
// Per-packet VLAN lookup: ingress filter, egress members, tag strip.
// Assumes packet descriptors come from logic on the fabric clock.
`timescale 1ns/10ps
module vta_lookup (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Table contents
   vta_tbl_if.user tbl,
   // Per-port controls
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] admit_nonmember_control,
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] egress_port_type_config,
   // Packet descriptor
   input wire logic pkt_valid,
   input wire logic [1:0] pkt_port,
   input wire logic pkt_tagged,
   input wire logic [11:0] pkt_vid,
   input wire logic [2:0] pkt_pri,
   // Lookup result
   output logic res_valid,
   output logic res_accept,
   output logic [11:0] res_vid,
   output logic [2:0] res_pri,
   output logic [vta_pkg::VTA_NUM_PORT-1:0] res_egress_member,
   output logic [vta_pkg::VTA_NUM_PORT-1:0] res_strip_tag
);
   import vta_pkg::*;

   logic port_ok;
   logic [14:0] pdef;
   logic [11:0] eff_vid;
   logic [2:0] eff_pri;
   logic [VTA_NUM_VLAN-1:0] hit;
   logic any_hit;
   logic [17:0] sel_entry;
   logic [VTA_NUM_PORT-1:0] member;
   logic [VTA_NUM_PORT-1:0] untag;

   // ==========================================================
   // Effective VID and priority
   assign port_ok = pkt_port < 2'(VTA_NUM_PORT);
   assign pdef = port_ok ? tbl.port_default[pkt_port] : VTA_PDEF_RST;

   // Untagged or null-tagged frames take the port defaults
   always_comb begin
      if (!pkt_tagged || pkt_vid == VTA_NULL_VID) begin
         eff_vid = pdef[VTA_F_VID_MSB:0];
         eff_pri = pdef[VTA_F_PRI_MSB:VTA_F_PRI_LSB];
      end else begin
         eff_vid = pkt_vid;
         eff_pri = pkt_pri;
      end
   end

   // ==========================================================
   // Entry match, null VID entries never hit
   genvar gi;
   generate
      for (gi = 0; gi < VTA_NUM_VLAN; gi++) begin : g_match
         assign hit[gi] = tbl.vlan_entry[gi][VTA_F_VID_MSB:0] == eff_vid &&
                          tbl.vlan_entry[gi][VTA_F_VID_MSB:0] != VTA_NULL_VID;
      end
   endgenerate

   // Lowest matching index wins
   always_comb begin
      sel_entry = VTA_ENTRY_RST;
      any_hit = 1'b0;
      for (int i = VTA_NUM_VLAN - 1; i >= 0; i--) begin
         if (hit[i]) begin
            sel_entry = tbl.vlan_entry[i];
            any_hit = 1'b1;
         end
      end
   end

   // Member and untag bit pairs per port
   generate
      for (gi = 0; gi < VTA_NUM_PORT; gi++) begin : g_port
         assign member[gi] = sel_entry[VTA_F_MEMBER0 + 2 * gi];
         assign untag[gi] = sel_entry[VTA_F_UNTAG0 + 2 * gi];
      end
   endgenerate

   // ==========================================================
   // Registered result
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         res_valid <= 1'b0;
         res_accept <= 1'b0;
         res_vid <= 12'h000;
         res_pri <= 3'h0;
         res_egress_member <= '0;
         res_strip_tag <= '0;
      end else begin
         res_valid <= pkt_valid;
         res_vid <= eff_vid;
         res_pri <= eff_pri;
         // Member or admitted non-member passes ingress
         res_accept <= pkt_valid && port_ok &&
                       ((any_hit && member[pkt_port]) ||
                        admit_nonmember_control[pkt_port]);
         res_egress_member <= any_hit ? member : '0;
         // Strip only on hybrid egress members
         res_strip_tag <= (any_hit && port_ok && untag[pkt_port]) ?
                          (member & egress_port_type_config) : '0;
      end
   end

endmodule // vta_lookup

// ---- verilog/vta_pkg.sv ----
// Constants, field layout and types of the VLAN table access block.
// Assumes one switch fabric clock and a 32-bit Avalon-MM register bus.
package vta_pkg;

   // ==========================================================
   // Table sizes and widths
   localparam int unsigned VTA_NUM_VLAN = 16;
   localparam int unsigned VTA_NUM_PORT = 3;
   localparam int unsigned VTA_ENTRY_W = 18;
   localparam int unsigned VTA_PDEF_W = 15;
   localparam int unsigned VTA_ADDR_W = 16;

   // ==========================================================
   // Register indices and byte addresses (index times four)
   localparam logic [15:0] VTA_IDX_CMD = 16'h180b;
   localparam logic [15:0] VTA_IDX_WR = 16'h180c;
   localparam logic [15:0] VTA_IDX_RD = 16'h180e;
   localparam logic [15:0] VTA_IDX_STS = 16'h1810;
   localparam logic [15:0] VTA_ADDR_CMD = {VTA_IDX_CMD[13:0], 2'b00};
   localparam logic [15:0] VTA_ADDR_WR = {VTA_IDX_WR[13:0], 2'b00};
   localparam logic [15:0] VTA_ADDR_RD = {VTA_IDX_RD[13:0], 2'b00};
   localparam logic [15:0] VTA_ADDR_STS = {VTA_IDX_STS[13:0], 2'b00};

   // ==========================================================
   // Entry fields
   localparam int unsigned VTA_F_UNTAG0 = 12;
   localparam int unsigned VTA_F_MEMBER0 = 13;
   localparam int unsigned VTA_F_PRI_LSB = 12;
   localparam int unsigned VTA_F_PRI_MSB = 14;
   localparam int unsigned VTA_F_VID_MSB = 11;
   localparam logic [11:0] VTA_NULL_VID = 12'h000;

   // ==========================================================
   // Command and status fields
   localparam int unsigned VTA_CMD_RNW = 5;
   localparam int unsigned VTA_CMD_SEL = 4;
   localparam int unsigned VTA_CMD_IDX_MSB = 3;
   localparam int unsigned VTA_STS_PEND = 0;

   // ==========================================================
   // Reset values
   localparam logic [17:0] VTA_ENTRY_RST = 18'h0_0000;
   localparam logic [14:0] VTA_PDEF_RST = 15'h0000;
   localparam logic [5:0] VTA_CMD_RST = 6'h00;
   localparam logic [31:0] VTA_RDATA_ZERO = 32'h0000_0000;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      VTA_IDLE = 2'b00,
      VTA_EXEC = 2'b01,
      VTA_DONE = 2'b11
   } vta_state_t;

   typedef enum logic [2:0] {
      VTA_SEL_NONE,
      VTA_SEL_CMD,
      VTA_SEL_WR,
      VTA_SEL_RD,
      VTA_SEL_STS
   } vta_sel_t;

endpackage

// ---- verilog/vta_tbl_if.sv ----
// Carries the table contents from the register side to the lookup.
// Assumes both ends sit on the same fabric clock.
`timescale 1ns/10ps
interface vta_tbl_if;
   import vta_pkg::*;
   logic [VTA_ENTRY_W-1:0] vlan_entry [VTA_NUM_VLAN];
   logic [VTA_PDEF_W-1:0] port_default [VTA_NUM_PORT];
   modport owner (output vlan_entry, output port_default);
   modport user (input vlan_entry, input port_default);
endinterface

// ---- verilog/vta_vlan_table.sv ----
// VLAN table and port default table with indirect register access.
// Assumes an Avalon-MM master on ref_clk and a fabric packet source.
//
// Operation
// - Untag bit of ingress port strips tag on hybrid egress ports.
// - Member bit one: matching packets accepted on that ingress port.
// - Member bit zero: drop on ingress unless admit-non-member set.
// - Egress broadcast domain holds exactly the member ports.
// - Port 1 member bit 15, port 0 member bit 13, reset zero.
// - Port 1 untag bit 14, port 0 untag bit 12, reset zero.
// - Entry VID in bits 11:0, matched against packet VID, reset zero.
// - VID zero disables an entry.
// - Port default: VID bits 11:0, priority 14:12, rest reserved.
// - Untagged or null-VID packets take the port default VID, priority.
// - Port defaults reset to VID zero and priority zero.
// - Read result: low 18 bits hold entry, upper bits read zero.
// - Command write starts access: bit5 read, bit4 table, 3:0 index.
// - Pending bit set during command, cleared by hardware on completion.
// - Port 2 member bit 17; same layout in write and read data.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
module vta_vlan_table (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [vta_pkg::VTA_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Per-port controls from the fabric
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] admit_nonmember_control,
   input wire logic [vta_pkg::VTA_NUM_PORT-1:0] egress_port_type_config,
   // Packet descriptor
   input wire logic pkt_valid,
   input wire logic [1:0] pkt_port,
   input wire logic pkt_tagged,
   input wire logic [11:0] pkt_vid,
   input wire logic [2:0] pkt_pri,
   // Lookup result
   output logic res_valid,
   output logic res_accept,
   output logic [11:0] res_vid,
   output logic [2:0] res_pri,
   output logic [vta_pkg::VTA_NUM_PORT-1:0] res_egress_member,
   output logic [vta_pkg::VTA_NUM_PORT-1:0] res_strip_tag
);
   import vta_pkg::*;

   // ==========================================================
   // Declarations
   vta_tbl_if tbl ();

   logic [VTA_ENTRY_W-1:0] vlan_mem [VTA_NUM_VLAN];
   logic [VTA_PDEF_W-1:0] pdef_mem [VTA_NUM_PORT];
   logic [5:0] vlan_table_command;
   logic [17:0] vlan_entry_write_staging;
   logic [17:0] vlan_entry_read_result;
   logic vlan_command_status;
   vta_state_t state;
   vta_state_t next_state;
   vta_sel_t bus_sel;
   logic bus_take;
   logic wr_take;
   logic cmd_start;
   logic [3:0] cmd_idx;
   logic cmd_rnw;
   logic cmd_pdef;
   logic pdef_idx_ok;
   logic [17:0] table_word;

   // ==========================================================
   // Address decode shared by read and write
   function automatic vta_sel_t decode_sel(input logic [VTA_ADDR_W-1:0] a);
      vta_sel_t s;
      s = VTA_SEL_NONE;
      if (a == VTA_ADDR_CMD) begin
         s = VTA_SEL_CMD;
      end else if (a == VTA_ADDR_WR) begin
         s = VTA_SEL_WR;
      end else if (a == VTA_ADDR_RD) begin
         s = VTA_SEL_RD;
      end else if (a == VTA_ADDR_STS) begin
         s = VTA_SEL_STS;
      end
      return s;
   endfunction

   // Bus-visible layout of a register
   function automatic logic [31:0] reg_word(input vta_sel_t s,
                                            input logic [5:0] cmd,
                                            input logic [17:0] wdat,
                                            input logic [17:0] rdat,
                                            input logic pend);
      logic [31:0] w;
      w = VTA_RDATA_ZERO;
      case (s)
         VTA_SEL_CMD: w[5:0] = cmd;
         VTA_SEL_WR: w[17:0] = wdat;
         VTA_SEL_RD: w[17:0] = rdat;
         VTA_SEL_STS: w[VTA_STS_PEND] = pend;
         default: w = VTA_RDATA_ZERO;
      endcase
      return w;
   endfunction

   assign bus_sel = decode_sel(avs_address);

   // Request taken at the edge where waitrequest is low
   assign bus_take = (avs_read || avs_write) && !avs_waitrequest;
   assign wr_take = bus_take && avs_write;

   // Command write with byte 0 enabled starts an access when idle
   assign cmd_start = wr_take && bus_sel == VTA_SEL_CMD &&
                      avs_byteenable[0] && !vlan_command_status;

   // ==========================================================
   // Fields of the latched command
   assign cmd_idx = vlan_table_command[VTA_CMD_IDX_MSB:0];
   assign cmd_rnw = vlan_table_command[VTA_CMD_RNW];
   assign cmd_pdef = vlan_table_command[VTA_CMD_SEL];
   assign pdef_idx_ok = cmd_idx < 4'(VTA_NUM_PORT);

   // Addressed table word, reserved default bits forced to zero
   always_comb begin
      table_word = VTA_ENTRY_RST;
      if (!cmd_pdef) begin
         table_word = vlan_mem[cmd_idx];
      end else if (pdef_idx_ok) begin
         table_word[VTA_PDEF_W-1:0] = pdef_mem[cmd_idx[1:0]];
      end
   end

   // ==========================================================
   // Wait state: one cycle of waitrequest per request
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Read data prepared while waitrequest is high
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         avs_readdata <= VTA_RDATA_ZERO;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= reg_word(bus_sel, vlan_table_command,
                                  vlan_entry_write_staging,
                                  vlan_entry_read_result,
                                  vlan_command_status);
      end
   end

   // ==========================================================
   // Command register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vlan_table_command <= VTA_CMD_RST;
      end else if (cmd_start) begin
         vlan_table_command <= avs_writedata[5:0];
      end
   end

   // Write staging register with byte enables
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vlan_entry_write_staging <= VTA_ENTRY_RST;
      end else if (wr_take && bus_sel == VTA_SEL_WR) begin
         if (avs_byteenable[0]) begin
            vlan_entry_write_staging[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            vlan_entry_write_staging[15:8] <= avs_writedata[15:8];
         end
         if (avs_byteenable[2]) begin
            vlan_entry_write_staging[17:16] <= avs_writedata[17:16];
         end
      end
   end

   // ==========================================================
   // Access sequencer
   always_comb begin
      next_state = state;
      case (state)
         VTA_IDLE: begin
            if (cmd_start) begin
               next_state = VTA_EXEC;
            end
         end
         VTA_EXEC: next_state = VTA_DONE;
         VTA_DONE: next_state = VTA_IDLE;
         default: next_state = VTA_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= VTA_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Pending from command write to completion
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vlan_command_status <= 1'b0;
      end else if (cmd_start) begin
         vlan_command_status <= 1'b1;
      end else if (state == VTA_DONE) begin
         vlan_command_status <= 1'b0;
      end
   end

   // ==========================================================
   // Read result, loaded only by a finishing read
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vlan_entry_read_result <= VTA_ENTRY_RST;
      end else if (state == VTA_EXEC && cmd_rnw) begin
         vlan_entry_read_result <= table_word;
      end
   end

   // VLAN table, one resettable word per entry
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < VTA_NUM_VLAN; i++) begin
            vlan_mem[i] <= VTA_ENTRY_RST;
         end
      end else if (state == VTA_EXEC && !cmd_rnw && !cmd_pdef) begin
         vlan_mem[cmd_idx] <= vlan_entry_write_staging;
      end
   end

   // Port default table, reserved bits not stored
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < VTA_NUM_PORT; i++) begin
            pdef_mem[i] <= VTA_PDEF_RST;
         end
      end else if (state == VTA_EXEC && !cmd_rnw && cmd_pdef && pdef_idx_ok) begin
         pdef_mem[cmd_idx[1:0]] <= vlan_entry_write_staging[VTA_PDEF_W-1:0];
      end
   end

   // ==========================================================
   // Table contents to the lookup
   always_comb begin
      for (int i = 0; i < VTA_NUM_VLAN; i++) begin
         tbl.vlan_entry[i] = vlan_mem[i];
      end
      for (int i = 0; i < VTA_NUM_PORT; i++) begin
         tbl.port_default[i] = pdef_mem[i];
      end
   end

   // Per-packet lookup
   vta_lookup u_lookup (
      .ref_clk(ref_clk),
      .rst(rst),
      .tbl(tbl.user),
      .admit_nonmember_control(admit_nonmember_control),
      .egress_port_type_config(egress_port_type_config),
      .pkt_valid(pkt_valid),
      .pkt_port(pkt_port),
      .pkt_tagged(pkt_tagged),
      .pkt_vid(pkt_vid),
      .pkt_pri(pkt_pri),
      .res_valid(res_valid),
      .res_accept(res_accept),
      .res_vid(res_vid),
      .res_pri(res_pri),
      .res_egress_member(res_egress_member),
      .res_strip_tag(res_strip_tag)
   );

endmodule // vta_vlan_table
